//--- rtl/otp_page_two_pkg.sv
// constants and carriers for the second otp page status block
// Operation
// - page_loaded bit 7 set once page two selected and copied into registers
// - load_corrected_warning bit 6 set when load saw single-bit corrections
// - load_uncorrectable_error bit 5 set on double-bit detection during load
// - format_fault bit 4 when either supply-clear flag set but no attempt
// - program_valid bit 3 set when page holds a valid programmed image and both supply-clear flags are set
// - prog_supply_low_clear bit 2 one only after attempt without undervoltage
// - prog_supply_high_clear bit 1 one only after attempt without overvoltage
// - overvoltage during programming also forces the undervoltage indication
// - first_attempt_flag bit 0 set once first programming attempt made
package otp_page_two_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [11:0] STATUS_INDEX  = 12'h51B;
  localparam logic [13:0] STATUS_ADDR   = {STATUS_INDEX, 2'b00};
  localparam logic [13:0] IRQ_STAT_ADDR = 14'h1500;
  localparam logic [13:0] IRQ_EN_ADDR   = 14'h1504;
  localparam logic [13:0] IRQ_CLR_ADDR  = 14'h1508;
  localparam logic [7:0]  STATUS_RESET  = 8'h00;
  localparam logic [2:0]  IRQ_RESET     = 3'h0;
  localparam logic [31:0] RDATA_RESET   = 32'h0000_0000;

  // ----------------------------------------
  // bit positions
  // ----------------------------------------
  localparam int LOADED_BIT  = 7;
  localparam int WARN_BIT    = 6;
  localparam int ERR_BIT     = 5;
  localparam int FMT_BIT     = 4;
  localparam int VALID_BIT   = 3;
  localparam int LOWOK_BIT   = 2;
  localparam int HIGHOK_BIT  = 1;
  localparam int ATTEMPT_BIT = 0;

  // interrupt bits: load done, load error, programming done
  localparam int IRQ_LOAD = 0;
  localparam int IRQ_LERR = 1;
  localparam int IRQ_PROG = 2;

  // events from the otp sequencer
  typedef struct packed {
    logic loadDone;
    logic singleBitCorrected;
    logic doubleBitDetected;
    logic progDone;
    logic progValid;
    logic supplyLow;
    logic supplyHigh;
  } otp_event_s;

  // ahb-lite slave request
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
  } ahb_req_s;

endpackage

//--- rtl/otp_page_two_status.sv
// status register for the second otp page with ahb-lite access and interrupt
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
module otp_page_two_status (
  // clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         reset,
  // otp sequencer events, one-cycle pulses
  input  wire otp_page_two_pkg::otp_event_s otpEvent,
  // ahb-lite slave
  input  wire otp_page_two_pkg::ahb_req_s   ahbReq,
  input  wire logic [31:0]                  hwdata,
  output logic [31:0]                       hrdata,
  output logic                              hreadyout,
  output logic                              hresp,
  // interrupt
  output logic                              irq
);

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // bits above the register window are unmapped rather than aliased
  function automatic logic inMap(input logic [31:0] addr);
    return addr[31:14] == 18'h0_0000;
  endfunction

  // one compare shared by every write decode
  function automatic logic hitReg(input logic        strobe,
                                  input logic [13:0] addr,
                                  input logic [13:0] target);
    return strobe && (addr == target);
  endfunction

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  logic [7:0] status_ff;
  logic [7:0] nxt_status;
  logic       lowOk;
  logic       highOk;

  always_comb begin
    nxt_status = status_ff;
    if (otpEvent.loadDone) begin
      nxt_status[otp_page_two_pkg::LOADED_BIT] = 1'b1;
      nxt_status[otp_page_two_pkg::WARN_BIT]   = otpEvent.singleBitCorrected;
      nxt_status[otp_page_two_pkg::ERR_BIT]    = otpEvent.doubleBitDetected;
    end
    if (otpEvent.progDone) begin
      // overvoltage shuts the supply down, so low also reads bad
      lowOk  = ~(otpEvent.supplyLow | otpEvent.supplyHigh);
      highOk = ~otpEvent.supplyHigh;
      nxt_status[otp_page_two_pkg::LOWOK_BIT]   = lowOk;
      nxt_status[otp_page_two_pkg::HIGHOK_BIT]  = highOk;
      nxt_status[otp_page_two_pkg::VALID_BIT]   = otpEvent.progValid & lowOk & highOk;
      nxt_status[otp_page_two_pkg::ATTEMPT_BIT] = 1'b1;
    end else begin
      lowOk  = 1'b0;
      highOk = 1'b0;
    end
    // fault is derived, so it tracks the other flags exactly
    nxt_status[otp_page_two_pkg::FMT_BIT] =
      (nxt_status[otp_page_two_pkg::LOWOK_BIT] | nxt_status[otp_page_two_pkg::HIGHOK_BIT])
      & ~nxt_status[otp_page_two_pkg::ATTEMPT_BIT];
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      status_ff <= otp_page_two_pkg::STATUS_RESET;
    end else begin
      status_ff <= nxt_status;
    end
  end

  // ----------------------------------------
  // ahb-lite address phase capture
  // ----------------------------------------
  logic        dValid_ff;
  logic        dWrite_ff;
  logic [13:0] dAddr_ff;
  logic        nxt_dValid;
  logic        nxt_dWrite;
  logic [13:0] nxt_dAddr;
  logic        takeReq;

  assign takeReq = ahbReq.hready & ahbReq.hsel & ahbReq.htrans[1] & inMap(ahbReq.haddr);

  always_comb begin
    nxt_dValid = takeReq;
    nxt_dWrite = dWrite_ff;
    nxt_dAddr  = dAddr_ff;
    if (takeReq) begin
      nxt_dWrite = ahbReq.hwrite;
      nxt_dAddr  = ahbReq.haddr[13:0];
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dValid_ff <= 1'b0;
      dWrite_ff <= 1'b0;
      dAddr_ff  <= 14'h0000;
    end else begin
      dValid_ff <= nxt_dValid;
      dWrite_ff <= nxt_dWrite;
      dAddr_ff  <= nxt_dAddr;
    end
  end

  // zero wait states; always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ----------------------------------------
  // interrupt registers
  // ----------------------------------------
  logic [2:0] irqStat_ff;
  logic [2:0] irqEn_ff;
  logic [2:0] nxt_irqStat;
  logic [2:0] nxt_irqEn;
  logic [2:0] irqSet;
  logic [2:0] irqClr;
  logic       wrStrobe;

  assign wrStrobe = dValid_ff & dWrite_ff;

  always_comb begin
    irqSet = 3'h0;
    irqSet[otp_page_two_pkg::IRQ_LOAD] = otpEvent.loadDone;
    irqSet[otp_page_two_pkg::IRQ_LERR] = otpEvent.loadDone & otpEvent.doubleBitDetected;
    irqSet[otp_page_two_pkg::IRQ_PROG] = otpEvent.progDone;
    irqClr = hitReg(wrStrobe, dAddr_ff, otp_page_two_pkg::IRQ_CLR_ADDR) ? hwdata[2:0] : 3'h0;
    // set wins over a clear in the same cycle
    nxt_irqStat = (irqStat_ff & ~irqClr) | irqSet;
    nxt_irqEn = hitReg(wrStrobe, dAddr_ff, otp_page_two_pkg::IRQ_EN_ADDR)
              ? hwdata[2:0] : irqEn_ff;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irqStat_ff <= otp_page_two_pkg::IRQ_RESET;
      irqEn_ff   <= otp_page_two_pkg::IRQ_RESET;
    end else begin
      irqStat_ff <= nxt_irqStat;
      irqEn_ff   <= nxt_irqEn;
    end
  end

  assign irq = |(irqStat_ff & irqEn_ff);

  // ----------------------------------------
  // read data, captured in the address phase
  // ----------------------------------------
  // status address has no write decode at all, so writes vanish
  // value frozen at the address edge; an event in the data phase shows on the next read
  logic [31:0] hrdata_ff;
  logic [31:0] nxt_hrdata;

  always_comb begin
    nxt_hrdata = otp_page_two_pkg::RDATA_RESET;
    if (takeReq && !ahbReq.hwrite) begin
      unique case (ahbReq.haddr[13:0])
        otp_page_two_pkg::STATUS_ADDR:   nxt_hrdata = {24'h00_0000, status_ff};
        otp_page_two_pkg::IRQ_STAT_ADDR: nxt_hrdata = {29'h0, irqStat_ff};
        otp_page_two_pkg::IRQ_EN_ADDR:   nxt_hrdata = {29'h0, irqEn_ff};
        default:                         nxt_hrdata = otp_page_two_pkg::RDATA_RESET;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      hrdata_ff <= otp_page_two_pkg::RDATA_RESET;
    end else begin
      hrdata_ff <= nxt_hrdata;
    end
  end

  assign hrdata = hrdata_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_loaded;
    @(posedge core_clk) disable iff (reset)
    otpEvent.loadDone |=> status_ff[otp_page_two_pkg::LOADED_BIT];
  endproperty
  a_loaded: assert property (p_loaded) else $error("loaded flag not set");

  property p_warn;
    @(posedge core_clk) disable iff (reset)
    otpEvent.loadDone |=> status_ff[6] == $past(otpEvent.singleBitCorrected);
  endproperty
  a_warn: assert property (p_warn) else $error("warning flag wrong");

  property p_err;
    @(posedge core_clk) disable iff (reset)
    otpEvent.loadDone |=> status_ff[5] == $past(otpEvent.doubleBitDetected);
  endproperty
  a_err: assert property (p_err) else $error("load error flag wrong");

  property p_fmt;
    @(posedge core_clk) disable iff (reset)
    status_ff[4] == ((status_ff[2] | status_ff[1]) & ~status_ff[0]);
  endproperty
  a_fmt: assert property (p_fmt) else $error("format fault mismatch");

  property p_valid;
    @(posedge core_clk) disable iff (reset)
    status_ff[3] |-> status_ff[2] & status_ff[1] & status_ff[0];
  endproperty
  a_valid: assert property (p_valid) else $error("valid without clean attempt");

  property p_low;
    @(posedge core_clk) disable iff (reset)
    otpEvent.progDone && otpEvent.supplyLow |=> !status_ff[2];
  endproperty
  a_low: assert property (p_low) else $error("low clear after undervoltage");

  property p_high;
    @(posedge core_clk) disable iff (reset)
    otpEvent.progDone && otpEvent.supplyHigh |=> !status_ff[1] && !status_ff[2];
  endproperty
  a_high: assert property (p_high) else $error("overvoltage not reported");

  property p_attempt;
    @(posedge core_clk) disable iff (reset)
    otpEvent.progDone |=> status_ff[0] ##1 status_ff[0];
  endproperty
  a_attempt: assert property (p_attempt) else $error("attempt flag lost");

  property p_ro;
    @(posedge core_clk) disable iff (reset)
    !otpEvent.loadDone && !otpEvent.progDone |=> status_ff == $past(status_ff);
  endproperty
  a_ro: assert property (p_ro) else $error("status changed without event");

  sequence s_quiet;
    !otpEvent.loadDone && !otpEvent.progDone;
  endsequence

  sequence s_status_read;
    takeReq && !ahbReq.hwrite && ahbReq.haddr[13:0] == otp_page_two_pkg::STATUS_ADDR;
  endsequence

  sequence s_status_write;
    takeReq && ahbReq.hwrite && ahbReq.haddr[13:0] == otp_page_two_pkg::STATUS_ADDR;
  endsequence

  property p_loaded_hold;
    @(posedge core_clk) disable iff (reset)
    status_ff[7] |=> status_ff[7];
  endproperty
  a_loaded_hold: assert property (p_loaded_hold) else $error("loaded flag dropped");

  property p_valid_set;
    @(posedge core_clk) disable iff (reset)
    otpEvent.progDone && otpEvent.progValid && !otpEvent.supplyLow && !otpEvent.supplyHigh
      |=> status_ff[3];
  endproperty
  a_valid_set: assert property (p_valid_set) else $error("clean attempt not valid");

  property p_low_set;
    @(posedge core_clk) disable iff (reset)
    otpEvent.progDone && !otpEvent.supplyLow && !otpEvent.supplyHigh |=> status_ff[2];
  endproperty
  a_low_set: assert property (p_low_set) else $error("low clear not set");

  property p_high_set;
    @(posedge core_clk) disable iff (reset)
    otpEvent.progDone && !otpEvent.supplyHigh |=> status_ff[1];
  endproperty
  a_high_set: assert property (p_high_set) else $error("high clear not set");

  property p_attempt_hold;
    @(posedge core_clk) disable iff (reset)
    status_ff[0] |=> status_ff[0];
  endproperty
  a_attempt_hold: assert property (p_attempt_hold) else $error("attempt flag dropped");

  property p_read_status;
    @(posedge core_clk) disable iff (reset)
    s_status_read |=> hrdata == {24'h00_0000, $past(status_ff)};
  endproperty
  a_read_status: assert property (p_read_status) else $error("status read wrong");

  property p_read_keeps;
    @(posedge core_clk) disable iff (reset)
    s_status_read ##1 s_quiet |=> status_ff == $past(status_ff);
  endproperty
  a_read_keeps: assert property (p_read_keeps) else $error("read changed status");

  property p_write_ignored;
    @(posedge core_clk) disable iff (reset)
    s_status_write ##1 s_quiet |=> status_ff == $past(status_ff);
  endproperty
  a_write_ignored: assert property (p_write_ignored) else $error("write changed status");

  property p_irq_set;
    @(posedge core_clk) disable iff (reset)
    otpEvent.loadDone |=> irqStat_ff[otp_page_two_pkg::IRQ_LOAD];
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("load interrupt not set");

  property p_irq_clear;
    @(posedge core_clk) disable iff (reset)
    hitReg(wrStrobe, dAddr_ff, otp_page_two_pkg::IRQ_CLR_ADDR) && hwdata[0] && !otpEvent.loadDone
      |=> !irqStat_ff[0];
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("load interrupt not cleared");

  property p_irq_enable;
    @(posedge core_clk) disable iff (reset)
    hitReg(wrStrobe, dAddr_ff, otp_page_two_pkg::IRQ_EN_ADDR)
      |=> irqEn_ff == $past(hwdata[2:0]);
  endproperty
  a_irq_enable: assert property (p_irq_enable) else $error("enable write lost");

endmodule

//--- test/otp_page_two_status_tb.sv
// self-checking bench for the second otp page status block
`timescale 1ns/1ps
module otp_page_two_status_tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic                          core_clk;
  logic                          reset;
  otp_page_two_pkg::otp_event_s  otpEvent;
  otp_page_two_pkg::ahb_req_s    ahbReq;
  logic                          sel;
  logic [31:0]                   addr;
  logic [1:0]                    trans;
  logic                          wr;
  logic [31:0]                   hwdata;
  logic [31:0]                   hrdata;
  logic                          hreadyout;
  logic                          hresp;
  logic                          irq;
  logic [31:0]                   rd;
  int                            nFail;
  int                            totalChecks;
  int                            cycles;
  // rows: {event bits, expected status}; each event overwrites its own flags
  logic [14:0]                   rows [7] = '{15'h4080, 15'h60C0, 15'h50A0, 15'h0CAF,
                                              15'h0EA3, 15'h0DA1, 15'h70E1};
  localparam logic [31:0] ST = 32'(otp_page_two_pkg::STATUS_ADDR);
  localparam logic [31:0] IS = 32'(otp_page_two_pkg::IRQ_STAT_ADDR);
  localparam logic [31:0] IE = 32'(otp_page_two_pkg::IRQ_EN_ADDR);
  localparam logic [31:0] IC = 32'(otp_page_two_pkg::IRQ_CLR_ADDR);
  // bus hready is the single slave's hreadyout
  assign ahbReq = {sel, addr, trans, wr, 3'h2, hreadyout};
  otp_page_two_status dut (.core_clk(core_clk), .reset(reset), .otpEvent(otpEvent),
    .ahbReq(ahbReq), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irq(irq));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    sel <= 1'b1; addr <= a; trans <= 2'h2; wr <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    sel <= 1'b0; trans <= 2'h0; wr <= 1'b0; hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask
  task automatic pulse(input logic [6:0] e);
    @(posedge core_clk);
    otpEvent <= e;
    @(posedge core_clk);
    otpEvent <= '0;
  endtask
  task automatic complete_run;
    if (nFail == 0 && totalChecks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // clock, timeout, sequence
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      nFail++;
      complete_run;
    end
  end
  initial begin
    reset = 1'b1; otpEvent = '0; sel = 1'b0; addr = '0; trans = 2'h0;
    wr = 1'b0; hwdata = '0; nFail = 0; totalChecks = 0; cycles = 0;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    bus(1'b0, ST, 32'h0);
    check(rd, 32'h0);
    // programming only starts while format_fault reads clear
    check({31'h0, rd[otp_page_two_pkg::FMT_BIT]}, 32'h0);
    for (int i = 0; i < 7; i++) begin
      pulse(rows[i][14:8]);
      bus(1'b0, ST, 32'h0);
      check(rd, {24'h0, rows[i][7:0]});
    end
    // writes must not disturb the flags, nor must reads clear them
    bus(1'b1, ST, 32'hFFFF_FFFF);
    bus(1'b0, ST, 32'h0);
    check(rd, 32'hE1);
    bus(1'b0, ST, 32'h0);
    check(rd, 32'hE1);
    bus(1'b0, 32'h100, 32'h0);
    check(rd, 32'h0);
    // interrupt: raise, mask, clear
    bus(1'b1, IS, 32'h0);
    bus(1'b0, IS, 32'h0);
    check(rd, 32'h7);
    check({31'h0, irq}, 32'h0);
    bus(1'b1, IE, 32'h1);
    @(posedge core_clk);
    check({31'h0, irq}, 32'h1);
    bus(1'b1, IC, 32'h1);
    @(posedge core_clk);
    check({31'h0, irq}, 32'h0);
    bus(1'b0, IS, 32'h0);
    check(rd, 32'h6);
    bus(1'b1, IE, 32'h4);
    @(posedge core_clk);
    check({31'h0, irq}, 32'h1);
    // second reset in mid-run returns everything to zero
    @(posedge core_clk);
    reset <= 1'b1;
    @(posedge core_clk);
    reset <= 1'b0;
    check({31'h0, irq}, 32'h0);
    bus(1'b0, ST, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, IE, 32'h0);
    check(rd, 32'h0);
    complete_run;
  end
endmodule
